// [rtl/xsde_regs.svh]
// Encodings, field positions and reset values for the instruction executer
`ifndef XSDE_REGS_SVH
`define XSDE_REGS_SVH

`define XSDE_OPC_HI        13
`define XSDE_OPC_LO        8
`define XSDE_DEST_BIT      7
`define XSDE_ADDR_HI       6
`define XSDE_ADDR_LO       0
`define XSDE_LIT_HI        7
`define XSDE_LIT_LO        0
`define XSDE_OPC_XORLIT    6'h3a
`define XSDE_OPC_XORREG    6'h06
`define XSDE_OPC_SWAP      6'h0e
`define XSDE_DIRLOAD_HI    14'h0060
`define XSDE_DIRLOAD_MASK  14'h3ff8
`define XSDE_DIR_FIRST     3'h5
`define XSDE_DIR_LAST      3'h7
`define XSDE_ACC_RESET     8'h00
`define XSDE_DIR_RESET     8'hff
`define XSDE_MEM_DEPTH     128
`define XSDE_MEM_INIT      8'h00

`endif

// [rtl/xsde_pkg.sv]
// Types shared by the instruction executer files
`default_nettype none
package xsde_pkg;
  typedef enum logic [2:0] {
    XSDE_NOP,
    XSDE_XOR_LIT,
    XSDE_XOR_REG,
    XSDE_SWAP,
    XSDE_DIR_LOAD
  } xsde_op_t;
  typedef enum {
    XSDE_IDLE,
    XSDE_EXEC
  } xsde_state_t;
endpackage
`default_nettype wire

// [rtl/xsde_mem_if.sv]
// Port bundle between the executer and its data memory
`timescale 1ns/1ps
`default_nettype none
interface xsde_mem_if;
  logic       rd_en;
  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  logic       wr_en;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  modport core (output rd_en, output rd_addr, input rd_data,
                output wr_en, output wr_addr, output wr_data);
  modport mem (input rd_en, input rd_addr, output rd_data,
               input wr_en, input wr_addr, input wr_data);
endinterface
`default_nettype wire

// [rtl/xsde_data_mem.sv]
// Data memory of 128 bytes with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "xsde_regs.svh"
module xsde_data_mem
  import xsde_pkg::*;
(
  input  wire logic sys_clk,
  xsde_mem_if.mem   port
);
  logic [7:0] store [0:`XSDE_MEM_DEPTH-1] = '{default: `XSDE_MEM_INIT};

  // No reset so it maps to RAM; contents start from a known fill
  always_ff @(posedge sys_clk) begin
    if (port.wr_en) begin
      store[port.wr_addr] <= port.wr_data;
    end
  end

  // Registered read port
  always_ff @(posedge sys_clk) begin
    if (port.rd_en) begin
      port.rd_data <= store[port.rd_addr];
    end
  end
endmodule
`default_nettype wire

// [rtl/xsde_exec.sv]
// Decoder and executer for exclusive OR, nibble swap and direction load
// Summary of operation
// RULE1: The literal exclusive OR decodes opcode bits 13:8 and XORs the accumulator with bits 7:0.
// RULE2: The literal exclusive OR always writes the accumulator and never a memory register.
// RULE3: The register exclusive OR decodes its opcode and 7-bit address and XORs acc with that register.
// RULE4: With destination bit clear the register XOR writes the accumulator only.
// RULE5: With destination bit set the register XOR writes the register only.
// RULE6: The direction load copies the accumulator into direction register 5 to 7.
// RULE7: The nibble swap exchanges register nibbles, routed by the destination bit, with no flags.
`timescale 1ns/1ps
`default_nettype none
`include "xsde_regs.svh"
module xsde_exec
  import xsde_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        instr_valid,
  input  wire logic [13:0] instr_word,
  output logic             instr_ready,
  output logic             done,
  output logic [7:0]       acc,
  input  wire logic        dir_wr_en,
  input  wire logic [1:0]  dir_wr_sel,
  input  wire logic [7:0]  dir_wr_data,
  output logic [7:0]       dir_reg_5,
  output logic [7:0]       dir_reg_6,
  output logic [7:0]       dir_reg_7,
  input  wire logic        dbg_rd_en,
  input  wire logic [6:0]  dbg_rd_addr,
  output logic [7:0]       dbg_rd_data
);
  logic             rst_meta;
  logic             rst_sync_b;
  xsde_state_t      state;
  xsde_op_t         op;
  xsde_op_t         next_op;
  logic             dest;
  logic [6:0]       addr;
  logic [7:0]       lit;
  logic [1:0]       dir_idx;
  logic [7:0]       result;
  logic [7:0]       dir_bank [0:2];
  logic             rd_pending;
  logic [5:0]       opc_field;
  logic             is_lit;
  logic             is_reg;
  logic             is_swap;
  logic             is_dir;
  logic             fetch_op;
  logic             dbg_fetch;
  xsde_mem_if       mem_bus ();

  // Reset release through two flops
  // Assert is immediate; release lags two edges so no flop leaves reset mid-edge
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta   <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_b <= rst_meta;
    end
  end

  xsde_data_mem xsde_data_mem_inst (
    .sys_clk (sys_clk),
    .port    (mem_bus.mem)
  );

  // Opcode field shared by the fixed-format forms
  assign opc_field = instr_word[`XSDE_OPC_HI:`XSDE_OPC_LO];

  // RULE1: literal opcode match
  assign is_lit  = (opc_field == `XSDE_OPC_XORLIT);
  // RULE3: register opcode match
  assign is_reg  = (opc_field == `XSDE_OPC_XORREG);
  // RULE7: swap opcode match
  assign is_swap = (opc_field == `XSDE_OPC_SWAP);
  // RULE6: direction load, operand 5 to 7 only
  assign is_dir  = ((instr_word & `XSDE_DIRLOAD_MASK) == `XSDE_DIRLOAD_HI)
                   && (instr_word[2:0] >= `XSDE_DIR_FIRST);

  // Opcode decode; anything unmatched runs as a no-op
  always_comb begin
    next_op = XSDE_NOP;
    if (is_lit) begin
      next_op = XSDE_XOR_LIT;
    end else if (is_reg) begin
      next_op = XSDE_XOR_REG;
    end else if (is_swap) begin
      next_op = XSDE_SWAP;
    end else if (is_dir) begin
      next_op = XSDE_DIR_LOAD;
    end
  end

  // One instruction in flight; memory read takes a cycle
  assign instr_ready = (state == XSDE_IDLE);

  // RULE3: operand fetch on acceptance
  assign fetch_op  = instr_valid && instr_ready
                     && (is_reg || is_swap);
  // Debug peek only while no operand is due, so it never steals the port
  // A peek that meets a write-back of the same byte sees the old value
  assign dbg_fetch = dbg_rd_en && !fetch_op;

  // Read port shared by operand fetch and debug peek
  assign mem_bus.rd_en   = fetch_op || dbg_fetch;
  assign mem_bus.rd_addr = fetch_op ? instr_word[`XSDE_ADDR_HI:`XSDE_ADDR_LO]
                           : dbg_rd_addr;
  // Read register shown only while the peek gate is open
  assign dbg_rd_data     = dbg_rd_en ? mem_bus.rd_data : 8'h00;

  // Capture the instruction fields at acceptance
  // Fields are held through the execute cycle, since the word
  // on the pins may change as soon as it has been taken
  // Cycle 0 takes the word, cycle 1 executes, done follows
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state <= XSDE_IDLE;
      op    <= XSDE_NOP;
      dest  <= 1'b0;
      addr  <= 7'h00;
      lit   <= 8'h00;
    end else begin
      case (state)
        XSDE_IDLE: begin
          if (instr_valid) begin
            state <= XSDE_EXEC;
            op    <= next_op;
            dest  <= instr_word[`XSDE_DEST_BIT];
            addr  <= instr_word[`XSDE_ADDR_HI:`XSDE_ADDR_LO];
            lit   <= instr_word[`XSDE_LIT_HI:`XSDE_LIT_LO];
          end
        end
        XSDE_EXEC: begin
          state <= XSDE_IDLE;
        end
        default: begin
          state <= XSDE_IDLE;
        end
      endcase
    end
  end

  // Execute cycle; the operand read data stand here
  assign rd_pending = (state == XSDE_EXEC);
  assign dir_idx    = 2'(addr[2:0] - `XSDE_DIR_FIRST);

  // Arithmetic of the executing instruction
  always_comb begin
    case (op)
      // RULE1: literal XOR
      XSDE_XOR_LIT: result = acc ^ lit;
      // RULE3: register XOR
      XSDE_XOR_REG: result = acc ^ mem_bus.rd_data;
      // No flags are produced, so the swap changes none
      // RULE7: nibble exchange
      XSDE_SWAP:    result = {mem_bus.rd_data[3:0], mem_bus.rd_data[7:4]};
      default:      result = acc;
    endcase
  end

  // Write-back lands at the end of the execute cycle
  // RULE5: register destination when bit set
  // RULE2: literal form never writes memory
  assign mem_bus.wr_en   = rd_pending && dest
                           && (op == XSDE_XOR_REG || op == XSDE_SWAP);
  assign mem_bus.wr_addr = addr;
  assign mem_bus.wr_data = result;

  // Accumulator update
  // Only the execute cycle may change it, so it holds between instructions
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      acc <= `XSDE_ACC_RESET;
    end else if (rd_pending) begin
      // RULE2: literal always lands in acc
      if (op == XSDE_XOR_LIT) begin
        acc <= result;
      // RULE4: acc destination when bit clear
      end else if (!dest && (op == XSDE_XOR_REG || op == XSDE_SWAP)) begin
        acc <= result;
      end
    end
  end

  // Completion pulse, one per instruction
  // Acc, memory and direction bank already hold the result here
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      done <= 1'b0;
    end else begin
      done <= rd_pending;
    end
  end

  // Direction registers; instruction load wins over direct write
  // Direct select 3 matches no entry and is dropped
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_dir
      always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          dir_bank[g] <= `XSDE_DIR_RESET;
        // RULE6: accumulator copy
        end else if (rd_pending && op == XSDE_DIR_LOAD && dir_idx == 2'(g)) begin
          dir_bank[g] <= acc;
        // RULE6: direct write stays available
        end else if (dir_wr_en && dir_wr_sel == 2'(g)) begin
          dir_bank[g] <= dir_wr_data;
        end
      end
    end
  endgenerate

  // Bank flattened onto the named ports
  assign dir_reg_5 = dir_bank[0];
  assign dir_reg_6 = dir_bank[1];
  assign dir_reg_7 = dir_bank[2];
endmodule
`default_nettype wire

// [bench/xsde_exec_monitor.sv]
// Port-level checks on the instruction executer
`timescale 1ns/1ps
`default_nettype none
module xsde_exec_monitor (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        instr_valid,
  input wire logic [13:0] instr_word,
  input wire logic        instr_ready,
  input wire logic        done,
  input wire logic [7:0]  acc,
  input wire logic [7:0]  dir_reg_5,
  input wire logic [7:0]  dir_reg_6,
  input wire logic [7:0]  dir_reg_7,
  input wire logic        dbg_rd_en,
  input wire logic [7:0]  dbg_rd_data
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Accepted instruction and its opcode class
  wire       take = instr_valid && instr_ready;
  wire [5:0] opc  = instr_word[13:8];
  wire       dl   = take && instr_word[13:3] == 11'h00c;
  take_walk_a: assert property (take |=> !instr_ready && !done ##1 done ##1 !done)
    else $error("done or ready off the two cycle walk");
  lit_xor_a: assert property (take && opc == 6'h3a |=> ##1
    acc == ($past(acc, 2) ^ $past(instr_word[7:0], 2))) else $error("literal xor wrong");
  lit_keep_dir_a: assert property (take && opc == 6'h3a |=> ##1
    {dir_reg_5, dir_reg_6, dir_reg_7} == $past({dir_reg_5, dir_reg_6, dir_reg_7}, 2))
    else $error("literal xor touched a register");
  reg_keep_acc_a: assert property (take && opc == 6'h06 && instr_word[7] |=> ##1
    acc == $past(acc, 2)) else $error("register xor to memory changed acc");
  swap_keep_acc_a: assert property (take && opc == 6'h0e && instr_word[7] |=> ##1
    acc == $past(acc, 2)) else $error("swap to memory changed acc");
  dir_load_a: assert property (dl && instr_word[2:0] >= 3'h5 |=> ##1 acc ==
    ($past(instr_word[2:0], 2) == 3'h5 ? dir_reg_5 :
     $past(instr_word[2:0], 2) == 3'h6 ? dir_reg_6 : dir_reg_7)) else $error("dir load wrong");
  dir_ignore_a: assert property (dl && instr_word[2:0] < 3'h5 |=> ##1
    {dir_reg_5, dir_reg_6, dir_reg_7} == $past({dir_reg_5, dir_reg_6, dir_reg_7}, 2))
    else $error("dir load with low operand changed a register");
  dbg_gate_a: assert property (!dbg_rd_en |-> dbg_rd_data == 8'h00)
    else $error("operand view not gated");
endmodule
bind xsde_exec xsde_exec_monitor xsde_exec_monitor_inst (.sys_clk, .rst_b, .instr_valid,
  .instr_word, .instr_ready, .done, .acc, .dir_reg_5, .dir_reg_6, .dir_reg_7, .dbg_rd_en,
  .dbg_rd_data);
`default_nettype wire

// [bench/xor_swap_dirload_exec_bench.sv]
// Self-checking bench for the instruction executer
`timescale 1ns/1ps
`default_nettype none
`include "xsde_regs.svh"
module xor_swap_dirload_exec_bench;
  logic        sys_clk, instr_ready, done;
  logic        rst_b = 1'b0, instr_valid = 1'b0, dir_wr_en = 1'b0, dbg_rd_en = 1'b0;
  logic        peek_due = 1'b0;
  logic [13:0] instr_word = 14'h0000;
  logic [1:0]  dir_wr_sel = 2'h0;
  logic [6:0]  dbg_rd_addr = 7'h00;
  logic [6:0]  a = 7'h00;
  logic [7:0]  dir_wr_data = 8'h00, acc, dir_reg_5, dir_reg_6, dir_reg_7, dbg_rd_data;
  logic [7:0]  acc_m = 8'h00;
  logic [7:0]  dir_m [5:7] = '{default: 8'hff};
  logic [7:0]  mem_m [0:127] = '{default: `XSDE_MEM_INIT};
  logic [31:0] notes [$];
  logic [7:0]  peeks [$];
  int          errors = 0, total_checks = 0, cycles = 0, i;
  integer      seed = 32'ha8f9;
  xsde_exec xsde_exec_inst (.sys_clk, .rst_b, .instr_valid, .instr_word, .instr_ready, .done,
    .acc, .dir_wr_en, .dir_wr_sel, .dir_wr_data, .dir_reg_5, .dir_reg_6, .dir_reg_7,
    .dbg_rd_en, .dbg_rd_addr, .dbg_rd_data);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cmp_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic print_verdict;
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Model the effect, note it, then offer the word until taken
  task automatic run(input logic [13:0] w);
    logic [7:0] r;
    if (w[13:8] == 6'h3a) acc_m ^= w[7:0];
    // register xor and swap, routed by the destination bit
    if (w[13:8] == 6'h06 || w[13:8] == 6'h0e) begin
      r = (w[13:8] == 6'h06) ? (acc_m ^ mem_m[w[6:0]])
          : {mem_m[w[6:0]][3:0], mem_m[w[6:0]][7:4]};
      if (w[7]) mem_m[w[6:0]] = r;
      else acc_m = r;
    end
    if (w[13:3] == 11'h00c && w[2:0] >= 3'h5) dir_m[w[2:0]] = acc_m;
    notes.push_back({acc_m, dir_m[5], dir_m[6], dir_m[7]});
    while (instr_ready !== 1'b1) @(posedge sys_clk) #1;
    instr_valid = 1'b1;
    instr_word = w;
    @(posedge sys_clk) #1;
    instr_valid = 1'b0;
  endtask
  // Peek one memory byte once the last write-back has landed
  task automatic peek(input logic [6:0] addr);
    peeks.push_back(mem_m[addr]);
    while (instr_ready !== 1'b1) @(posedge sys_clk) #1;
    dbg_rd_en = 1'b1;
    dbg_rd_addr = addr;
    @(posedge sys_clk) #1;
    peek_due = 1'b1;
    @(posedge sys_clk) #1;
    peek_due = 1'b0;
    dbg_rd_en = 1'b0;
    @(posedge sys_clk) #1;
  endtask
  // Result watcher on the falling edge, clear of the edge that launches outputs
  always @(negedge sys_clk) begin
    cycles++;
    if (done === 1'b1) begin
      if (notes.size() == 0) cmp("stray done", 32'h0, 32'h1);
      else cmp("state", notes.pop_front(), {acc, dir_reg_5, dir_reg_6, dir_reg_7});
    end
    if (peek_due === 1'b1) begin
      cmp_byte("memory", peeks.pop_front(), dbg_rd_data);
    end
  end
  initial begin
    fork
      begin
        repeat (2) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        repeat (3) @(posedge sys_clk) #1;
        cmp("reset", {8'h00, 24'hffffff}, {acc, dir_reg_5, dir_reg_6, dir_reg_7});
        cmp("idle flags", 32'h2, {instr_ready, done});
        run({6'h3a, 8'hb5});
        run({6'h3a, 8'haf});
        for (i = 0; i < 12; i++) run({6'h3a, 8'($random(seed))});
        for (i = 0; i < 8; i++) begin
          run({6'h3a, 8'($random(seed))});
          run({11'h00c, 3'(i)});
        end
        // Register forms on random bytes, both destinations, each memory-destination form and the literal followed by a peek
        for (i = 0; i < 6; i++) begin
          a = 7'($random(seed));
          run({6'h06, 1'b1, a});
          peek(a);
          run({6'h06, 1'b0, a});
          run({6'h0e, 1'b1, a});
          peek(a);
          run({6'h0e, 1'b0, a});
          run({6'h3a, 8'($random(seed))});
          peek(a);
        end
        run(14'h3fff);
        run({6'h3a, 8'hff});
        repeat (4) @(posedge sys_clk) #1;
        // Direct writes keep the direction registers reachable; select 3 is dropped
        for (i = 0; i < 4; i++) begin
          dir_wr_en = 1'b1;
          dir_wr_sel = 2'(i);
          dir_wr_data = 8'($random(seed));
          if (i < 3) dir_m[i + 5] = dir_wr_data;
          @(posedge sys_clk) #1;
          dir_wr_en = 1'b0;
          @(posedge sys_clk) #1;
          cmp("direct", {acc_m, dir_m[5], dir_m[6], dir_m[7]},
              {acc, dir_reg_5, dir_reg_6, dir_reg_7});
        end
        cmp("pending notes", 32'h0, 32'(notes.size()));
      end
      begin
        // Hang limit, far above the few hundred cycles the run needs
        wait (cycles >= 1000);
        errors++;
      end
    join_any
    print_verdict;
  end
endmodule
`default_nettype wire
